// file: port_ctrl_pkg.sv
// Constants for the per-port clock, pin and loopback control bank.
// Assumes a 32-bit classic Wishbone bus with byte addressing.
package port_ctrl_pkg;

  // Bus geometry
  localparam int ADR_W = 12;
  localparam int IDX_W = 10;

  // Register word indices; byte address is four times the index
  localparam logic [IDX_W-1:0] CLK_PIN_CTRL_IDX = 10'h014;
  localparam logic [IDX_W-1:0] LOOP_ALARM_CTRL_IDX = 10'h046;

  // Reset values and writable-bit masks
  localparam logic [15:0] CLK_PIN_CTRL_RST = 16'h0000;
  localparam logic [15:0] LOOP_ALARM_CTRL_RST = 16'h0000;
  localparam logic [15:0] CLK_PIN_CTRL_MASK = 16'h36FF;
  localparam logic [15:0] LOOP_ALARM_CTRL_MASK = 16'h07FF;

  // Clock/pin control field positions
  localparam int RX_CLOCK_PIN_SELECT_BIT = 13;
  localparam int RX_FRAME_PIN_SELECT_BIT = 12;
  localparam int TX_CLOCK_PIN_SELECT_BIT = 10;
  localparam int TX_FRAME_PIN_SELECT_BIT = 9;
  localparam int PORT_REF_SOURCE_SELECT_HI = 7;
  localparam int PORT_REF_SOURCE_SELECT_LO = 6;
  localparam int SECOND_TIMER_REF_SELECT_BIT = 5;
  localparam int LOOP_TIMING_ENABLE_BIT = 4;
  localparam int RATE_ADAPTER_TX_DISABLE_BIT = 3;
  localparam int RX_FRAMER_PIN_TIMING_BIT = 2;
  localparam int TX_FRAMER_PIN_TIMING_BIT = 1;
  localparam int TX_LINE_PIN_TIMING_BIT = 0;

  // Loopback and alarm pin field positions
  localparam int LOOPBACK_SELECT_HI = 10;
  localparam int LOOPBACK_SELECT_LO = 8;
  localparam int SECOND_PIN_ALARM_SELECT_HI = 7;
  localparam int SECOND_PIN_ALARM_SELECT_LO = 4;
  localparam int FIRST_PIN_ALARM_SELECT_HI = 3;
  localparam int FIRST_PIN_ALARM_SELECT_LO = 0;

  // Port reference source codes
  localparam logic [1:0] PORT_REF_RX_FRAMER = 2'h2;
  localparam logic [1:0] PORT_REF_TX_FRAMER = 2'h3;

  // Alarm vector positions
  localparam int ALARM_COUNT = 6;
  localparam int ALARM_LINE_LOS = 0;
  localparam int ALARM_OOF = 1;
  localparam int ALARM_LOF = 2;
  localparam int ALARM_AIS = 3;
  localparam int ALARM_RAI = 4;
  localparam int ALARM_IDLE = 5;

  // Loopback vector positions
  localparam int LOOP_ANALOG = 0;
  localparam int LOOP_LINE = 1;
  localparam int LOOP_PAYLOAD = 2;
  localparam int LOOP_DIAG = 3;

  // Transmit clock source
  typedef enum logic [1:0] {
    TX_SRC_INPUT_PIN = 2'h0,
    TX_SRC_RX_LINE = 2'h1,
    TX_SRC_RECOVERED = 2'h2,
    TX_SRC_RATE_ADAPTER = 2'h3
  } tx_clk_src_t;

  // Bus slave states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'h0,
    BUS_ACK = 2'h1
  } bus_state_t;

endpackage

// file: alarm_pin_select.sv
// Alarm multiplexer for one general-purpose pin.
// Assumes alarm inputs and enable are synchronous to clk_i.
`timescale 1ns/1ps
module alarm_pin_select #(
  parameter int ALARM_W = 6
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Selection
  input wire logic [3:0] code_i,
  input wire logic [ALARM_W-1:0] alarms_i,
  input wire logic enable_i,
  // Pin drive
  output logic pin_o,
  output logic pin_oe_o
);
  import port_ctrl_pkg::*;

  typedef struct packed {
    logic pin;
    logic oe;
  } sel_state_t;

  sel_state_t st_reg;
  sel_state_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.oe = enable_i;
    case (code_i)
      4'h0: st_next.pin = alarms_i[ALARM_LINE_LOS];
      4'h1: st_next.pin = alarms_i[ALARM_OOF];
      4'h2: st_next.pin = alarms_i[ALARM_LOF];
      4'h3: st_next.pin = alarms_i[ALARM_AIS];
      4'h4: st_next.pin = alarms_i[ALARM_RAI];
      4'h5: st_next.pin = alarms_i[ALARM_IDLE];
      4'hB, 4'hD: st_next.pin = alarms_i[ALARM_LINE_LOS] | alarms_i[ALARM_LOF] | alarms_i[ALARM_AIS];
      4'hE: st_next.pin = alarms_i[ALARM_RAI] | alarms_i[ALARM_IDLE];
      4'hF: st_next.pin = |alarms_i;
      default: st_next.pin = 1'b0;
    endcase
    // Pin level only meaningful while enabled for output
    if (!enable_i) begin
      st_next.pin = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pin_o = st_reg.pin;
  assign pin_oe_o = st_reg.oe;

endmodule // alarm_pin_select

// file: port_clock_loopback_control.sv
// Per-port clock pin, reference, loopback and alarm pin control bank.
// Assumes a 32-bit classic Wishbone master on clk_i and same-clock port signals.
//
// Functional notes
// - Bit 13 routes receive clock pin: gapped clock when clear, clock output when set.
// - Bit 12 routes receive frame pin: data enable when clear, frame start when set.
// - Bit 10 routes transmit clock pin: gapped clock when clear, clock output when set.
// - Bit 9 routes transmit frame pin: data enable when clear, frame start when set.
// - Port 8 kHz reference: code 10 receive framer, 11 transmit framer, 0X undefined.
// - Bit 5 picks the one-second timer reference: global or the port's own.
// - Bit 4 loop timing takes transmit clock from receive side, ignoring input pin, unless bit 3 is clear and the rate adapter is needed.
// - Bit 3 set forbids rate-adapter transmit clock; input pin used without loopback.
// - Bit 2 selects receive framer pin timing: output clocks or input clocks.
// - Bit 1 selects transmit framer pin timing: output clocks or input clocks.
// - Bit 0 selects transmit line pin timing: output clocks or input clocks.
// - Three-bit loopback field decodes analog, line, payload, diagnostic combinations.
// - Bits 7..4 choose the alarm on the second pin when enabled.
// - Bits 3..0 choose the alarm on the first pin when enabled.
// - Alarm codes map single alarms and OR combinations; 1111 ORs all six.
`timescale 1ns/1ps
module port_clock_loopback_control (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [port_ctrl_pkg::ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Receive side sources for shared pins
  input wire logic rx_gapped_clock_i,
  input wire logic rx_clock_output_i,
  input wire logic rx_frame_start_out_i,
  input wire logic rx_data_enable_i,
  // Transmit side sources for shared pins
  input wire logic tx_gapped_clock_i,
  input wire logic tx_clock_output_i,
  input wire logic tx_frame_start_out_i,
  input wire logic tx_data_enable_i,
  // Shared pin levels
  output logic rx_clock_pin_o,
  output logic rx_frame_pin_o,
  output logic tx_clock_pin_o,
  output logic tx_frame_pin_o,
  // 8 kHz references
  input wire logic rx_framer_8k_i,
  input wire logic tx_framer_8k_i,
  input wire logic global_8k_i,
  output logic port_ref_8k_o,
  output logic port_ref_valid_o,
  output logic second_timer_ref_o,
  // Transmit clock source steering
  input wire logic line_interface_enabled_i,
  input wire logic rate_adapter_needed_i,
  output port_ctrl_pkg::tx_clk_src_t tx_clock_source_o,
  // Pin timing references
  output logic rx_framer_pin_timing_o,
  output logic tx_framer_pin_timing_o,
  output logic tx_line_pin_timing_o,
  // Loopbacks
  output logic analog_loop_o,
  output logic line_loop_o,
  output logic payload_loop_o,
  output logic diagnostic_loop_o,
  // Alarm status and general-purpose pins
  input wire logic [port_ctrl_pkg::ALARM_COUNT-1:0] alarms_i,
  input wire logic first_pin_output_enable_i,
  input wire logic second_pin_output_enable_i,
  output logic first_pin_o,
  output logic first_pin_oe_o,
  output logic second_pin_o,
  output logic second_pin_oe_o
);
  import port_ctrl_pkg::*;

  typedef struct packed {
    bus_state_t bus;
    logic [31:0] rdata;
    logic [15:0] clk_ctrl;
    logic [15:0] loop_ctrl;
    logic rx_clk_pin;
    logic rx_frame_pin;
    logic tx_clk_pin;
    logic tx_frame_pin;
    logic port_ref;
    logic port_ref_valid;
    logic timer_ref;
    tx_clk_src_t tx_src;
    logic [3:0] loops;
  } ctrl_state_t;

  ctrl_state_t st_reg;
  ctrl_state_t st_next;

  logic req;
  logic [IDX_W-1:0] word_idx;
  logic hit_clk;
  logic hit_loop;
  logic [15:0] lane_mask;
  logic [1:0] ref_sel;
  logic [2:0] loop_sel;
  logic any_loop;

  assign req = cyc_i & stb_i;
  assign word_idx = adr_i[ADR_W-1:2];
  assign hit_clk = (word_idx == CLK_PIN_CTRL_IDX);
  assign hit_loop = (word_idx == LOOP_ALARM_CTRL_IDX);
  assign lane_mask = {{8{sel_i[1]}}, {8{sel_i[0]}}};
  assign ref_sel = st_reg.clk_ctrl[PORT_REF_SOURCE_SELECT_HI:PORT_REF_SOURCE_SELECT_LO];
  assign loop_sel = st_reg.loop_ctrl[LOOPBACK_SELECT_HI:LOOPBACK_SELECT_LO];
  assign any_loop = |st_reg.loops;

  always_comb begin
    st_next = st_reg;

    // Bus slave: one wait cycle, ack for one cycle, then release
    case (st_reg.bus)
      BUS_IDLE: begin
        if (req) begin
          st_next.bus = BUS_ACK;
          st_next.rdata = 32'h0000_0000;
          if (hit_clk) begin
            st_next.rdata = {16'h0000, st_reg.clk_ctrl};
          end else if (hit_loop) begin
            st_next.rdata = {16'h0000, st_reg.loop_ctrl};
          end
          if (we_i && hit_clk) begin
            st_next.clk_ctrl = ((st_reg.clk_ctrl & ~lane_mask) | (dat_i[15:0] & lane_mask))
                               & CLK_PIN_CTRL_MASK;
          end
          if (we_i && hit_loop) begin
            st_next.loop_ctrl = ((st_reg.loop_ctrl & ~lane_mask) | (dat_i[15:0] & lane_mask))
                                & LOOP_ALARM_CTRL_MASK;
          end
        end
      end
      BUS_ACK: begin
        st_next.bus = BUS_IDLE;
      end
      default: begin
        st_next.bus = BUS_IDLE;
      end
    endcase

    // Shared pin functions
    st_next.rx_clk_pin = st_reg.clk_ctrl[RX_CLOCK_PIN_SELECT_BIT] ?
                         rx_clock_output_i : rx_gapped_clock_i;
    st_next.rx_frame_pin = st_reg.clk_ctrl[RX_FRAME_PIN_SELECT_BIT] ?
                           rx_frame_start_out_i : rx_data_enable_i;
    st_next.tx_clk_pin = st_reg.clk_ctrl[TX_CLOCK_PIN_SELECT_BIT] ?
                         tx_clock_output_i : tx_gapped_clock_i;
    st_next.tx_frame_pin = st_reg.clk_ctrl[TX_FRAME_PIN_SELECT_BIT] ?
                           tx_frame_start_out_i : tx_data_enable_i;

    // Port 8 kHz reference; undefined codes give a low level and no valid
    case (ref_sel)
      PORT_REF_RX_FRAMER: begin
        st_next.port_ref = rx_framer_8k_i;
        st_next.port_ref_valid = 1'b1;
      end
      PORT_REF_TX_FRAMER: begin
        st_next.port_ref = tx_framer_8k_i;
        st_next.port_ref_valid = 1'b1;
      end
      default: begin
        st_next.port_ref = 1'b0;
        st_next.port_ref_valid = 1'b0;
      end
    endcase

    // One-second timer reference
    if (st_reg.clk_ctrl[SECOND_TIMER_REF_SELECT_BIT]) begin
      st_next.timer_ref = st_next.port_ref;
    end else begin
      st_next.timer_ref = global_8k_i;
    end

    // Loopback decode
    case (loop_sel)
      3'h0: st_next.loops = 4'h0;
      3'h1: st_next.loops = 4'h1 << LOOP_ANALOG;
      3'h2: st_next.loops = 4'h1 << LOOP_LINE;
      3'h3: st_next.loops = 4'h1 << LOOP_PAYLOAD;
      3'h6: st_next.loops = (4'h1 << LOOP_LINE) | (4'h1 << LOOP_DIAG);
      default: st_next.loops = 4'h1 << LOOP_DIAG;
    endcase

    // Transmit clock source
    if (st_reg.clk_ctrl[LOOP_TIMING_ENABLE_BIT]) begin
      if (!st_reg.clk_ctrl[RATE_ADAPTER_TX_DISABLE_BIT] && rate_adapter_needed_i) begin
        st_next.tx_src = TX_SRC_RATE_ADAPTER;
      end else if (line_interface_enabled_i) begin
        st_next.tx_src = TX_SRC_RECOVERED;
      end else begin
        st_next.tx_src = TX_SRC_RX_LINE;
      end
    end else if (!st_reg.clk_ctrl[RATE_ADAPTER_TX_DISABLE_BIT] && rate_adapter_needed_i) begin
      st_next.tx_src = TX_SRC_RATE_ADAPTER;
    end else if (any_loop) begin
      // Loopbacks time transmit from the receive line side
      st_next.tx_src = line_interface_enabled_i ? TX_SRC_RECOVERED : TX_SRC_RX_LINE;
    end else begin
      st_next.tx_src = TX_SRC_INPUT_PIN;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
      st_reg.bus <= BUS_IDLE;
      st_reg.clk_ctrl <= CLK_PIN_CTRL_RST;
      st_reg.loop_ctrl <= LOOP_ALARM_CTRL_RST;
      st_reg.tx_src <= TX_SRC_INPUT_PIN;
    end else begin
      st_reg <= st_next;
    end
  end

  // Alarm pins
  alarm_pin_select #(
    .ALARM_W(ALARM_COUNT)
  ) first_pin_sel (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .code_i(st_reg.loop_ctrl[FIRST_PIN_ALARM_SELECT_HI:FIRST_PIN_ALARM_SELECT_LO]),
    .alarms_i(alarms_i),
    .enable_i(first_pin_output_enable_i),
    .pin_o(first_pin_o),
    .pin_oe_o(first_pin_oe_o)
  );

  alarm_pin_select #(
    .ALARM_W(ALARM_COUNT)
  ) second_pin_sel (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .code_i(st_reg.loop_ctrl[SECOND_PIN_ALARM_SELECT_HI:SECOND_PIN_ALARM_SELECT_LO]),
    .alarms_i(alarms_i),
    .enable_i(second_pin_output_enable_i),
    .pin_o(second_pin_o),
    .pin_oe_o(second_pin_oe_o)
  );

  // Outputs
  assign ack_o = (st_reg.bus == BUS_ACK);
  assign dat_o = st_reg.rdata;
  assign rx_clock_pin_o = st_reg.rx_clk_pin;
  assign rx_frame_pin_o = st_reg.rx_frame_pin;
  assign tx_clock_pin_o = st_reg.tx_clk_pin;
  assign tx_frame_pin_o = st_reg.tx_frame_pin;
  assign port_ref_8k_o = st_reg.port_ref;
  assign port_ref_valid_o = st_reg.port_ref_valid;
  assign second_timer_ref_o = st_reg.timer_ref;
  assign tx_clock_source_o = st_reg.tx_src;
  assign rx_framer_pin_timing_o = st_reg.clk_ctrl[RX_FRAMER_PIN_TIMING_BIT];
  assign tx_framer_pin_timing_o = st_reg.clk_ctrl[TX_FRAMER_PIN_TIMING_BIT];
  assign tx_line_pin_timing_o = st_reg.clk_ctrl[TX_LINE_PIN_TIMING_BIT];
  assign analog_loop_o = st_reg.loops[LOOP_ANALOG];
  assign line_loop_o = st_reg.loops[LOOP_LINE];
  assign payload_loop_o = st_reg.loops[LOOP_PAYLOAD];
  assign diagnostic_loop_o = st_reg.loops[LOOP_DIAG];

endmodule // port_clock_loopback_control

// file: port_ctrl_asserts.sv
// Checker for the port clock, loopback and alarm pin control bank.
// Assumes a classic Wishbone master that releases each request at its ack edge.
`timescale 1ns/1ps
module port_ctrl_asserts
  import port_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // Watched pins
  input wire logic rx_gapped_clock_i,
  input wire logic rx_clock_output_i,
  input wire logic rx_clock_pin_o,
  input wire logic rx_framer_pin_timing_o,
  input wire logic tx_framer_pin_timing_o,
  input wire logic tx_line_pin_timing_o,
  input wire logic analog_loop_o,
  input wire logic diagnostic_loop_o,
  input wire logic port_ref_valid_o,
  input wire logic first_pin_output_enable_i,
  input wire logic first_pin_o,
  input wire logic first_pin_oe_o
);
  logic [15:0] cr3_s;
  logic [15:0] cr4_s;
  logic [9:0] idx;
  assign idx = adr_i[11:2];
  function automatic logic [15:0] upd(input logic [15:0] o, input logic [15:0] m);
    logic [15:0] be;
    be = {{8{sel_i[1]}}, {8{sel_i[0]}}} & m;
    return (o & ~be) | (dat_i[15:0] & be);
  endfunction
  // Shadow copy of both registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cr3_s <= 16'h0000;
      cr4_s <= 16'h0000;
    end else if (cyc_i && stb_i && we_i && !ack_o) begin
      if (idx == CLK_PIN_CTRL_IDX) cr3_s <= upd(cr3_s, CLK_PIN_CTRL_MASK);
      if (idx == LOOP_ALARM_CTRL_IDX) cr4_s <= upd(cr4_s, LOOP_ALARM_CTRL_MASK);
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_follows_req: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack missing");
  a_ack_one_pulse: assert property (ack_o |=> !ack_o) else $error("ack too long");
  a_read_data: assert property (ack_o && !we_i |-> dat_o == {16'h0000, $past(idx) == CLK_PIN_CTRL_IDX ? cr3_s :
    $past(idx) == LOOP_ALARM_CTRL_IDX ? cr4_s : 16'h0000}) else $error("read data wrong");
  a_rx_clock_pin: assert property (!$past(rst_i) |-> rx_clock_pin_o ==
    ($past(cr3_s[13]) ? $past(rx_clock_output_i) : $past(rx_gapped_clock_i))) else $error("rx clock pin wrong");
  a_timing_bits: assert property ({rx_framer_pin_timing_o, tx_framer_pin_timing_o,
    tx_line_pin_timing_o} == cr3_s[2:0]) else $error("timing bits wrong");
  a_loop_decode: assert property (!$past(rst_i) |-> diagnostic_loop_o == $past(cr4_s[10]) &&
    analog_loop_o == ($past(cr4_s[10:8]) == 3'h1)) else $error("loop decode wrong");
  a_ref_valid: assert property (!$past(rst_i) |-> port_ref_valid_o == $past(cr3_s[7]))
    else $error("ref valid wrong");
  a_alarm_pin_off: assert property (!$past(rst_i) && !$past(first_pin_output_enable_i) |->
    !first_pin_o && !first_pin_oe_o) else $error("alarm pin driven");
  c_write: cover property (cyc_i && stb_i && we_i && ack_o);
  c_diag: cover property (diagnostic_loop_o);
  c_alarm: cover property (first_pin_o);
endmodule // port_ctrl_asserts

bind port_clock_loopback_control port_ctrl_asserts u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
  .sel_i, .dat_i, .dat_o, .ack_o, .rx_gapped_clock_i, .rx_clock_output_i, .rx_clock_pin_o,
  .rx_framer_pin_timing_o, .tx_framer_pin_timing_o, .tx_line_pin_timing_o, .analog_loop_o,
  .diagnostic_loop_o, .port_ref_valid_o, .first_pin_output_enable_i, .first_pin_o, .first_pin_oe_o);

// file: port_clock_loopback_control_test.sv
// Self-checking bench for the port control bank.
// Assumes the checker is bound to the design; one 40 MHz clock.
`timescale 1ns/1ps
module port_clock_loopback_control_test;
  import port_ctrl_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [ADR_W-1:0] adr_i = '0;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = '0;
  logic [31:0] r = '0;
  logic [31:0] dat_o;
  logic ack_o, rx_gapped_clock_i, rx_clock_output_i, rx_frame_start_out_i, rx_data_enable_i;
  logic tx_gapped_clock_i, tx_clock_output_i, tx_frame_start_out_i, tx_data_enable_i;
  logic rx_clock_pin_o, rx_frame_pin_o, tx_clock_pin_o, tx_frame_pin_o, rx_framer_8k_i, tx_framer_8k_i;
  logic global_8k_i, port_ref_8k_o, port_ref_valid_o, second_timer_ref_o, line_interface_enabled_i;
  logic rate_adapter_needed_i, rx_framer_pin_timing_o, tx_framer_pin_timing_o, tx_line_pin_timing_o;
  logic analog_loop_o, line_loop_o, payload_loop_o, diagnostic_loop_o, first_pin_output_enable_i;
  logic second_pin_output_enable_i, first_pin_o, first_pin_oe_o, second_pin_o, second_pin_oe_o;
  logic [ALARM_COUNT-1:0] alarms_i;
  tx_clk_src_t tx_clock_source_o;
  int bad_count = 0;
  int compares = 0;
  // Random word feeds every port-side input
  assign {second_pin_output_enable_i, first_pin_output_enable_i, alarms_i, rate_adapter_needed_i,
    line_interface_enabled_i, global_8k_i, tx_framer_8k_i, rx_framer_8k_i, tx_data_enable_i,
    tx_frame_start_out_i, tx_clock_output_i, tx_gapped_clock_i, rx_data_enable_i, rx_frame_start_out_i,
    rx_clock_output_i, rx_gapped_clock_i} = r[20:0];
  port_clock_loopback_control dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
    .ack_o, .rx_gapped_clock_i, .rx_clock_output_i, .rx_frame_start_out_i, .rx_data_enable_i,
    .tx_gapped_clock_i, .tx_clock_output_i, .tx_frame_start_out_i, .tx_data_enable_i, .rx_clock_pin_o,
    .rx_frame_pin_o, .tx_clock_pin_o, .tx_frame_pin_o, .rx_framer_8k_i, .tx_framer_8k_i, .global_8k_i,
    .port_ref_8k_o, .port_ref_valid_o, .second_timer_ref_o, .line_interface_enabled_i,
    .rate_adapter_needed_i, .tx_clock_source_o, .rx_framer_pin_timing_o, .tx_framer_pin_timing_o,
    .tx_line_pin_timing_o, .analog_loop_o, .line_loop_o, .payload_loop_o, .diagnostic_loop_o, .alarms_i,
    .first_pin_output_enable_i, .second_pin_output_enable_i, .first_pin_o, .first_pin_oe_o,
    .second_pin_o, .second_pin_oe_o);
  always #12.5 clk_i = ~clk_i;
  task automatic final_report();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= s;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (n >= 20) begin
      bad_count++;
      final_report();
    end
  endtask
  function automatic logic alarm(input logic [3:0] c, input logic [5:0] a);
    case (c)
      4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5: return a[c];
      4'hB, 4'hD: return a[0] | a[2] | a[3];
      4'hE: return a[4] | a[5];
      4'hF: return |a;
      default: return 1'b0;
    endcase
  endfunction
  function automatic logic [3:0] loops(input logic [2:0] c);
    case (c)
      3'h0: return 4'h0;
      3'h1: return 4'h8;
      3'h2: return 4'h4;
      3'h3: return 4'h2;
      3'h6: return 4'h5;
      default: return 4'h1;
    endcase
  endfunction
  function automatic logic [1:0] src(input logic [15:0] c3, input logic [2:0] lb, input logic [31:0] v);
    if (!c3[3] && v[12]) return 2'h3;
    if (c3[4] || lb != 3'h0) return v[11] ? 2'h2 : 2'h1;
    return 2'h0;
  endfunction
  initial begin
    logic [31:0] q;
    logic [15:0] c3, c4;
    logic pref;
    void'($urandom(40));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b0, 12'h050, 32'h0, 4'h3, q);
    check(q, 32'h0, "clk reset");
    bus(1'b0, 12'h118, 32'h0, 4'h3, q);
    check(q, 32'h0, "loop reset");
    $display("test reset done");
    bus(1'b1, 12'h050, 32'hFFFFFFFF, 4'hF, q);
    bus(1'b1, 12'h118, 32'hFFFFFFFF, 4'hF, q);
    bus(1'b1, 12'h060, 32'hFFFFFFFF, 4'hF, q);
    bus(1'b0, 12'h050, 32'h0, 4'h3, q);
    check(q, 32'h000036FF, "clk mask");
    bus(1'b0, 12'h118, 32'h0, 4'h3, q);
    check(q, 32'h000007FF, "loop mask");
    bus(1'b0, 12'h060, 32'h0, 4'h3, q);
    check(q, 32'h0, "unmapped");
    bus(1'b1, 12'h050, 32'h0, 4'h1, q);
    bus(1'b0, 12'h050, 32'h0, 4'h3, q);
    check(q, 32'h00003600, "byte lane");
    $display("test masks done");
    for (int i = 0; i < 48; i++) begin
      c3 = 16'($urandom);
      c4 = i < 16 ? {5'h00, 3'(i), 4'(i), 4'(15 - i)} : 16'($urandom);
      bus(1'b1, 12'h050, {16'h0000, c3}, 4'h3, q);
      bus(1'b1, 12'h118, {16'h0000, c4}, 4'h3, q);
      r <= $urandom | (i < 16 ? 32'h00180000 : 32'h0);
      repeat (3) @(posedge clk_i);
      #1;
      pref = c3[7] & (c3[6] ? r[9] : r[8]);
      check({rx_clock_pin_o, rx_frame_pin_o, tx_clock_pin_o, tx_frame_pin_o}, {c3[13] ? r[1] : r[0],
        c3[12] ? r[2] : r[3], c3[10] ? r[5] : r[4], c3[9] ? r[6] : r[7]}, "pins");
      check({port_ref_8k_o, port_ref_valid_o, second_timer_ref_o, rx_framer_pin_timing_o,
        tx_framer_pin_timing_o, tx_line_pin_timing_o}, {pref, c3[7], c3[5] ? pref : r[10], c3[2:0]}, "refs");
      check(tx_clock_source_o, src(c3, c4[10:8], r), "tx source");
      check({analog_loop_o, line_loop_o, payload_loop_o, diagnostic_loop_o}, loops(c4[10:8]), "loops");
      check({first_pin_o, first_pin_oe_o, second_pin_o, second_pin_oe_o}, {r[19] & alarm(c4[3:0], r[18:13]),
        r[19], r[20] & alarm(c4[7:4], r[18:13]), r[20]}, "alarms");
    end
    $display("test fields done");
    // Mid-run reset must clear both registers and the loop decode
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b0, 12'h050, 32'h0, 4'h3, q);
    check(q, 32'h0, "clk after reset");
    bus(1'b0, 12'h118, 32'h0, 4'h3, q);
    check(q, 32'h0, "loop after reset");
    check({analog_loop_o, line_loop_o, payload_loop_o, diagnostic_loop_o}, 32'h0, "loops after reset");
    $display("test mid reset done");
    final_report();
  end
endmodule // port_clock_loopback_control_test
